//--- hw/fdio_pkg.sv
// Package for the fieldbus digital I/O node: constants and types.
// Assumes a 20 MHz system clock; times are converted to cycle counts here.
package fdio_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned WDOG_DEF_S      = 10;
   localparam int unsigned REPLY_DEF_US    = 0;
   localparam int unsigned US_DIV          = 1_000_000;
   localparam int unsigned CYC_PER_US      = CLK_HZ / US_DIV;
   localparam int unsigned SEC_CYC         = CLK_HZ;

   // ---------------------------------------------------------------
   // Bus parameters
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W          = 7;
   localparam logic [6:0]  ADDR_MIN        = 7'h01;
   localparam logic [6:0]  ADDR_MAX        = 7'h7F;
   localparam logic [6:0]  ADDR_RST        = 7'h01;
   localparam int unsigned WDOG_W          = 16;
   localparam int unsigned REPLY_W         = 16;
   localparam logic [15:0] WDOG_RST        = 16'h000A;
   localparam logic [15:0] REPLY_RST       = 16'h0000;

   // Local bus bit-rate codes
   typedef enum logic [2:0] {
      FDIO_BR_19200,
      FDIO_BR_38400,
      FDIO_BR_57500,
      FDIO_BR_93750,
      FDIO_BR_115200,
      FDIO_BR_187500,
      FDIO_BR_500K,
      FDIO_BR_1500K
   } fdio_rate_e;
   localparam logic [2:0]  RATE_RST        = 3'h0;

   // CAN bit rate
   localparam int unsigned CAN_RATE_W      = 21;
   localparam logic [20:0] CAN_RATE_RST    = 21'h01E848;

   // Output mode per channel
   localparam logic        MODE_HOST       = 1'b0;
   localparam logic        MODE_PROC       = 1'b1;

endpackage

//--- hw/fdio_cfg_shadow.sv
// Double-buffered configuration holder.
// Assumes a load strobe from the same clock; staged values never leak.
`timescale 1ns/1ps
`default_nettype none
module fdio_cfg_shadow #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Staging side
   input  wire logic [WIDTH-1:0] stage_in,
   input  wire logic             stage_we_in,
   input  wire logic             commit_in,
   // Active value
   output logic      [WIDTH-1:0] active_out
);
   logic [WIDTH-1:0] stage_q;

   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least one");
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         stage_q <= RST_VAL;
      end else if (stage_we_in) begin
         stage_q <= stage_in;
      end
   end

   // Old value stays until the whole set is committed
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         active_out <= RST_VAL;
      end else if (commit_in) begin
         active_out <= stage_q;
      end
   end
endmodule
`default_nettype wire

//--- hw/fdio_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module fdio_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Pins
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least one");
   end

   // First stage read only by the second
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- hw/fdio_node.sv
// Fieldbus digital I/O node core: inputs, outputs, watchdog, reply delay.
// Assumes a frame decoder in the clk_in domain delivers request strobes
// with the addressed node number; the transmitter waits on reply_go_out.
`timescale 1ns/1ps
`default_nettype none

module fdio_node
   import fdio_pkg::*;
#(
   parameter int unsigned N_IN      = 8,
   parameter int unsigned N_OUT     = 8,
   parameter int unsigned N_THR     = 4,
   parameter int unsigned SEC_CYCLES = fdio_pkg::SEC_CYC
) (
   // Clock and reset
   input  wire logic                             clk_in,
   input  wire logic                             reset_in,
   // Pins
   input  wire logic [N_IN-1:0]                  din_pin_in,
   output logic      [N_OUT-1:0]                 dout_pin_out,
   // Decoded host requests
   input  wire logic                             req_valid_in,
   input  wire logic [fdio_pkg::ADDR_W-1:0]      req_addr_in,
   input  wire logic                             req_wr_out_in,
   input  wire logic [N_OUT-1:0]                 req_out_data_in,
   // Process threshold flags, one group per output
   input  wire logic [N_OUT*N_THR-1:0]           thr_hit_in,
   // Configuration staging
   input  wire logic                             cfg_we_in,
   input  wire logic                             cfg_commit_in,
   input  wire logic [fdio_pkg::ADDR_W-1:0]      cfg_addr_in,
   input  wire logic [2:0]                       cfg_rate_in,
   input  wire logic [fdio_pkg::WDOG_W-1:0]      cfg_wdog_s_in,
   input  wire logic [fdio_pkg::REPLY_W-1:0]     cfg_reply_us_in,
   input  wire logic [fdio_pkg::CAN_RATE_W-1:0]  cfg_can_rate_in,
   input  wire logic [N_OUT-1:0]                 cfg_mode_in,
   input  wire logic [N_OUT-1:0]                 cfg_polarity_in,
   input  wire logic [N_OUT*N_THR-1:0]           cfg_thr_en_in,
   input  wire logic [N_OUT-1:0]                 cfg_safe_in,
   input  wire logic                             cfg_restore_in,
   // Status towards the bus side
   output logic      [N_IN-1:0]                  din_state_out,
   output logic      [N_OUT-1:0]                 dout_state_out,
   output logic                                  req_match_out,
   output logic                                  reply_go_out,
   output logic                                  wdog_timeout_out,
   output logic      [2:0]                       rate_out,
   output logic      [fdio_pkg::CAN_RATE_W-1:0]  can_rate_out
);
   import fdio_pkg::*;

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   initial begin
      if (N_IN < 1 || N_OUT < 1 || N_THR < 1) $error("bad channel counts");
      if (SEC_CYCLES < 1) $error("SEC_CYCLES must be at least one");
   end

   localparam int unsigned SEC_W = $clog2(SEC_CYCLES + 1);
   localparam int unsigned CFG_W = ADDR_W + 3 + WDOG_W + REPLY_W
                                 + CAN_RATE_W + 3*N_OUT + N_OUT*N_THR + 1;

   // ---------------------------------------------------------------
   // Configuration shadow
   // ---------------------------------------------------------------
   logic [CFG_W-1:0]      cfg_stage;
   logic [CFG_W-1:0]      cfg_act;
   logic [ADDR_W-1:0]     addr_a;
   logic [2:0]            rate_a;
   logic [WDOG_W-1:0]     wdog_a;
   logic [REPLY_W-1:0]    reply_a;
   logic [CAN_RATE_W-1:0] can_a;
   logic [N_OUT-1:0]      mode_a;
   logic [N_OUT-1:0]      pol_a;
   logic [N_OUT*N_THR-1:0] thr_en_a;
   logic [N_OUT-1:0]      safe_a;
   logic                  restore_a;

   localparam logic [CFG_W-1:0] CFG_RST = {ADDR_RST, RATE_RST, WDOG_RST,
      REPLY_RST, CAN_RATE_RST, {N_OUT{MODE_HOST}}, {N_OUT{1'b0}},
      {(N_OUT*N_THR){1'b0}}, {N_OUT{1'b0}}, 1'b0};

   assign cfg_stage = {cfg_addr_in, cfg_rate_in, cfg_wdog_s_in,
      cfg_reply_us_in, cfg_can_rate_in, cfg_mode_in, cfg_polarity_in,
      cfg_thr_en_in, cfg_safe_in, cfg_restore_in};

   // Whole set swaps in one edge on commit
   fdio_cfg_shadow #(
      .WIDTH   (CFG_W),
      .RST_VAL (CFG_RST)
   ) u_cfg (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .stage_in    (cfg_stage),
      .stage_we_in (cfg_we_in),
      .commit_in   (cfg_commit_in),
      .active_out  (cfg_act)
   );

   assign {addr_a, rate_a, wdog_a, reply_a, can_a, mode_a, pol_a,
           thr_en_a, safe_a, restore_a} = cfg_act;

   // ---------------------------------------------------------------
   // Digital inputs
   // ---------------------------------------------------------------
   logic [N_IN-1:0] din_sync;

   fdio_sync #(
      .WIDTH (N_IN)
   ) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (din_pin_in),
      .sync_out (din_sync)
   );

   // High level is one, no inversion
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         din_state_out <= '0;
      end else begin
         din_state_out <= din_sync;
      end
   end

   // ---------------------------------------------------------------
   // Address match
   // ---------------------------------------------------------------
   // Address zero never matches; it lies outside the legal range
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] own);
      addr_ok = (own >= ADDR_MIN) && (own <= ADDR_MAX) && (a == own);
   endfunction

   logic hit;
   assign hit = req_valid_in && addr_ok(req_addr_in, addr_a);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         req_match_out <= 1'b0;
      end else begin
         req_match_out <= hit;
      end
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   logic [SEC_W-1:0]  sec_q;
   logic [WDOG_W-1:0] wsec_q;
   logic              tick;

   assign tick = (sec_q == SEC_W'(SEC_CYCLES - 1));

   always_ff @(posedge clk_in) begin
      if (reset_in || hit || tick) begin
         sec_q <= '0;
      end else begin
         sec_q <= sec_q + SEC_W'(1);
      end
   end

   // A zero period disables the watchdog
   always_ff @(posedge clk_in) begin
      if (reset_in || hit) begin
         wsec_q           <= '0;
         wdog_timeout_out <= 1'b0;
      end else if (tick && !wdog_timeout_out && wdog_a != '0) begin
         wsec_q <= wsec_q + WDOG_W'(1);
         if (wsec_q + WDOG_W'(1) >= wdog_a) begin
            wdog_timeout_out <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Host output values and safe latch
   // ---------------------------------------------------------------
   logic [N_OUT-1:0] host_q;
   logic             safe_hold_q;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         host_q <= '0;
      end else if (hit && req_wr_out_in) begin
         host_q <= req_out_data_in;
      end
   end

   // Without restore the safe state sticks until the host writes again
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         safe_hold_q <= 1'b0;
      end else if (wdog_timeout_out && !hit) begin
         safe_hold_q <= 1'b1;
      end else if (hit && (restore_a || req_wr_out_in)) begin
         safe_hold_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Output drive
   // ---------------------------------------------------------------
   logic [N_OUT-1:0] out_d;

   always_comb begin
      out_d = '0;
      for (int i = 0; i < N_OUT; i++) begin
         if (mode_a[i] == MODE_PROC) begin
            // Any enabled threshold asserts
            out_d[i] = (|(thr_hit_in[i*N_THR +: N_THR]
                          & thr_en_a[i*N_THR +: N_THR])) ^ pol_a[i];
         end else if (wdog_timeout_out || safe_hold_q) begin
            out_d[i] = safe_a[i];
         end else begin
            out_d[i] = host_q[i];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         dout_pin_out   <= '0;
         dout_state_out <= '0;
      end else begin
         dout_pin_out   <= out_d;
         dout_state_out <= out_d;
      end
   end

   // ---------------------------------------------------------------
   // Reply delay
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {FDIO_IDLE, FDIO_WAIT} fdio_rply_e;
   fdio_rply_e       rst_q;
   logic [31:0]      rcnt_q;
   logic [31:0]      rlim;

   assign rlim = 32'(reply_a) * 32'(CYC_PER_US);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rst_q        <= FDIO_IDLE;
         rcnt_q       <= '0;
         reply_go_out <= 1'b0;
      end else begin
         reply_go_out <= 1'b0;
         case (rst_q)
            FDIO_IDLE: begin
               if (hit) begin
                  rcnt_q <= '0;
                  if (rlim == '0) begin
                     reply_go_out <= 1'b1;
                  end else begin
                     rst_q <= FDIO_WAIT;
                  end
               end
            end
            FDIO_WAIT: begin
               rcnt_q <= rcnt_q + 32'h00000001;
               if (rcnt_q + 32'h00000001 >= rlim) begin
                  reply_go_out <= 1'b1;
                  rst_q        <= FDIO_IDLE;
               end
            end
            default: rst_q <= FDIO_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Rate settings
   // ---------------------------------------------------------------
   // Rates are codes only; the serialiser and CAN core do the timing
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rate_out     <= RATE_RST;
         can_rate_out <= CAN_RATE_RST;
      end else begin
         rate_out     <= rate_a;
         can_rate_out <= can_a;
      end
   end
endmodule
`default_nettype wire

//--- tb/fdio_node_asserts.sv
// Port-timing checker for the I/O node core.
// Assumes binding to fdio_node; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fdio_node_chk #(
   parameter int unsigned N_IN  = 8,
   parameter int unsigned N_OUT = 8
) (
   input wire logic [N_IN-1:0]  din_pin_in,
   input wire logic             clk_in,
   input wire logic             reset_in,
   input wire logic             req_valid_in,
   input wire logic [6:0]       req_addr_in,
   input wire logic             cfg_commit_in,
   input wire logic [N_IN-1:0]  din_state_out,
   input wire logic [N_OUT-1:0] dout_pin_out,
   input wire logic [N_OUT-1:0] dout_state_out,
   input wire logic             req_match_out,
   input wire logic             wdog_timeout_out,
   input wire logic [2:0]       rate_out,
   input wire logic [20:0]      can_rate_out
);
   // Pipeline age after reset; sync flops hold zero before that
   logic [1:0] age_q;
   always_ff @(posedge clk_in) begin
      if (reset_in) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_zero_req;
      req_valid_in && req_addr_in == 7'h00;
   endsequence
   sequence s_served;
      $past(req_valid_in) && $past(req_addr_in) != 7'h00;
   endsequence
   property p_din;
      age_q == 2'h3 |-> din_state_out == $past(din_pin_in, 3);
   endproperty
   property p_readback;
      dout_state_out == dout_pin_out;
   endproperty
   property p_match;
      req_match_out |-> s_served;
   endproperty
   property p_zero;
      s_zero_req |=> !req_match_out;
   endproperty
   property p_wd_clear;
      $fell(wdog_timeout_out) |-> req_match_out;
   endproperty
   property p_wd_rise;
      $rose(wdog_timeout_out) |-> !$past(req_match_out);
   endproperty
   property p_rate;
      $changed(rate_out) |-> $past(cfg_commit_in, 2);
   endproperty
   property p_can;
      $changed(can_rate_out) |-> $past(cfg_commit_in, 2);
   endproperty
   a_din: assert property (p_din)
      else $error("input state lags pins wrongly");
   a_readback: assert property (p_readback)
      else $error("output readback differs from pins");
   a_match: assert property (p_match)
      else $error("match without a request");
   a_zero: assert property (p_zero)
      else $error("address zero served");
   a_wd_clear: assert property (p_wd_clear)
      else $error("timeout cleared without a hit");
   a_wd_rise: assert property (p_wd_rise)
      else $error("timeout right after a hit");
   a_rate: assert property (p_rate)
      else $error("rate moved without commit");
   a_can: assert property (p_can)
      else $error("CAN rate moved without commit");
endmodule
bind fdio_node fdio_node_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) chk_u (
   .din_pin_in, .clk_in, .reset_in, .req_valid_in, .req_addr_in,
   .cfg_commit_in, .din_state_out, .dout_pin_out, .dout_state_out,
   .req_match_out, .wdog_timeout_out, .rate_out, .can_rate_out);
`default_nettype wire

//--- tb/fdio_host_model.sv
// Host side model: issues decoded one-cycle requests.
// Assumes the same clock as the node; one address per node.
`timescale 1ns/1ps
`default_nettype none
module fdio_host_model (
   // Clock
   input  wire logic clk_in,
   // Requests
   output logic       req_valid_out,
   output logic [6:0] req_addr_out,
   output logic       req_wr_out,
   output logic [7:0] req_data_out
);
   initial begin
      req_valid_out = 1'b0;
      req_addr_out  = 7'h7F;
      req_wr_out    = 1'b0;
      req_data_out  = 8'h00;
   end
   // Fields inverted after use so no stale value lingers
   // Same rate and unique address assumed
   task automatic send(input logic [6:0] a, input logic w,
                       input logic [7:0] d);
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b1;
      req_addr_out  = a;
      req_wr_out    = w;
      req_data_out  = d;
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b0;
      req_addr_out  = ~a;
      req_wr_out    = ~w;
      req_data_out  = ~d;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the I/O node core.
// Assumes a short second (SEC_CYCLES 10) to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fdio_pkg::*;
   logic        clk_in, reset_in, req_valid_in, req_wr_out_in;
   logic        req_match_out, reply_go_out, wdog_timeout_out;
   logic        cfg_we_in, cfg_commit_in, cfg_restore_in;
   logic [7:0]  din_pin_in, dout_pin_out, req_out_data_in, din_state_out;
   logic [7:0]  dout_state_out, cfg_mode_in, cfg_polarity_in, cfg_safe_in;
   logic [6:0]  req_addr_in, cfg_addr_in;
   logic [31:0] thr_hit_in, cfg_thr_en_in;
   logic [2:0]  cfg_rate_in, rate_out;
   logic [15:0] cfg_wdog_s_in, cfg_reply_us_in;
   logic [20:0] cfg_can_rate_in, can_rate_out;
   int          bad_count, checks_done, n;
   fdio_node #(.SEC_CYCLES(10)) dut_u (
      .clk_in, .reset_in, .din_pin_in, .dout_pin_out, .req_valid_in,
      .req_addr_in, .req_wr_out_in, .req_out_data_in, .thr_hit_in,
      .cfg_we_in, .cfg_commit_in, .cfg_addr_in, .cfg_rate_in,
      .cfg_wdog_s_in, .cfg_reply_us_in, .cfg_can_rate_in, .cfg_mode_in,
      .cfg_polarity_in, .cfg_thr_en_in, .cfg_safe_in, .cfg_restore_in,
      .din_state_out, .dout_state_out, .req_match_out, .reply_go_out,
      .wdog_timeout_out, .rate_out, .can_rate_out);
   fdio_host_model host_u (.clk_in, .req_valid_out(req_valid_in),
      .req_addr_out(req_addr_in), .req_wr_out(req_wr_out_in),
      .req_data_out(req_out_data_in));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bounded wait; n counts cycles after the request edge
   task automatic wait_sig(input bit sel, input int lim);
      n = 0;
      while ((sel ? wdog_timeout_out : reply_go_out) !== 1'b1) begin
         tick(1);
         n++;
         if (n > lim) begin
            bad_count++;
            $display("BAD %0t wait ran out", $time);
            tally_and_finish();
         end
      end
   endtask
   task automatic cfg_apply;
      cfg_we_in = 1'b1;
      tick(1);
      cfg_we_in = 1'b0;
      cfg_commit_in = 1'b1;
      tick(1);
      cfg_commit_in = 1'b0;
      tick(3);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_inputs;
      din_pin_in = 8'hA5;
      tick(4);
      chk(din_state_out, 8'hA5, "input capture");
      $display("done inputs");
   endtask
   task automatic t_host;
      // Match and reply pulses stand right after the request edge
      host_u.send(7'h01, 1'b1, 8'h3C);
      chk(req_match_out, 1'b1, "no match");
      chk(reply_go_out, 1'b1, "reply not prompt");
      tick(1);
      chk(dout_pin_out, 8'h3C, "host write");
      chk(dout_state_out, 8'h3C, "readback");
      $display("done host");
   endtask
   task automatic t_addr;
      logic [6:0] wrong [2] = '{7'h05, 7'h00};
      for (int i = 0; i < 2; i++) begin
         host_u.send(wrong[i], 1'b1, 8'hFF);
         chk(req_match_out, 1'b0, "foreign match");
         tick(1);
         chk(dout_pin_out, 8'h3C, "foreign write");
      end
      $display("done addr");
   endtask
   task automatic t_config;
      cfg_addr_in = 7'h05;
      cfg_wdog_s_in = 16'h0000;
      cfg_reply_us_in = 16'h0001;
      cfg_can_rate_in = 21'h01C200;
      cfg_rate_in = 3'h7;
      cfg_we_in = 1'b1;
      tick(1);
      cfg_we_in = 1'b0;
      tick(3);
      chk(rate_out, 3'h0, "staged rate leaked");
      chk(can_rate_out, CAN_RATE_RST, "staged CAN leaked");
      for (int r = 0; r < 8; r++) begin
         cfg_rate_in = r[2:0];
         cfg_apply();
         chk(rate_out, r[2:0], "rate code");
      end
      chk(can_rate_out, 21'h01C200, "CAN rate");
      host_u.send(7'h05, 1'b1, 8'h3C);
      wait_sig(1'b0, 60);
      chk(n, CYC_PER_US, "reply delay");
      $display("done config");
   endtask
   task automatic t_wdog;
      cfg_wdog_s_in = 16'h0002;
      cfg_safe_in = 8'h0F;
      cfg_restore_in = 1'b1;
      cfg_apply();
      host_u.send(7'h05, 1'b1, 8'hC3);
      wait_sig(1'b1, 40);
      chk(32'(n >= 20 && n <= 21), 32'h1, "timeout period");
      tick(2);
      chk(dout_pin_out, 8'h0F, "safe state");
      host_u.send(7'h05, 1'b0, 8'h00);
      tick(1);
      chk(wdog_timeout_out, 1'b0, "hit kept timeout");
      tick(1);
      chk(dout_pin_out, 8'hC3, "restore");
      // Without restore a plain hit must leave the safe state in place
      cfg_restore_in = 1'b0;
      cfg_apply();
      host_u.send(7'h05, 1'b0, 8'h00);
      wait_sig(1'b1, 40);
      host_u.send(7'h05, 1'b0, 8'h00);
      tick(2);
      chk(dout_pin_out, 8'h0F, "safe kept");
      host_u.send(7'h05, 1'b1, 8'hC3);
      tick(2);
      chk(dout_pin_out, 8'hC3, "write after safe");
      $display("done wdog");
   endtask
   task automatic t_proc;
      logic [31:0] hits [3] = '{32'h0, 32'h1, 32'h11};
      logic [1:0]  want [3] = '{2'h2, 2'h3, 2'h1};
      cfg_wdog_s_in = 16'h0000;
      cfg_mode_in = 8'h03;
      cfg_polarity_in = 8'h02;
      cfg_thr_en_in = 32'hFFFFFFFF;
      cfg_apply();
      for (int i = 0; i < 3; i++) begin
         thr_hit_in = hits[i];
         tick(2);
         chk(dout_pin_out[1:0], want[i], "process out");
      end
      chk(dout_pin_out[7:2], 6'h30, "host bits kept");
      $display("done proc");
   endtask
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      reset_in = 1'b1;
      din_pin_in = 8'h00;
      thr_hit_in = 32'h0;
      cfg_we_in = 1'b0;
      cfg_commit_in = 1'b0;
      cfg_addr_in = ADDR_RST;
      cfg_rate_in = RATE_RST;
      cfg_wdog_s_in = WDOG_RST;
      cfg_reply_us_in = REPLY_RST;
      cfg_can_rate_in = CAN_RATE_RST;
      cfg_mode_in = 8'h00;
      cfg_polarity_in = 8'h00;
      cfg_thr_en_in = 32'h0;
      cfg_safe_in = 8'h00;
      cfg_restore_in = 1'b0;
      bad_count = 0;
      checks_done = 0;
      tick(16);
      reset_in = 1'b0;
      chk(can_rate_out, 21'h01E848, "CAN default");
      t_inputs();
      t_host();
      t_addr();
      t_config();
      t_wdog();
      t_proc();
      tally_and_finish();
   end
endmodule
`default_nettype wire
